// [design/csc_pkg.sv]
// Shared constants and types for the codec serial clock and power control block
package csc_pkg;

  // Serial word and frame geometry
  localparam int XFER_BITS         = 16;
  localparam int FRAME_SCLK_SHORT  = 256;
  localparam int FRAME_SCLK_LONG   = 512;
  localparam int CASCADE_SHORT_MAX = 4;
  localparam int SC_W              = 9;
  localparam int CASCADE_W         = 4;

  // Master shift clock half period in system clocks
  localparam int SCLK_HALF_DEFAULT = 4;
  localparam int DIV_W             = 8;

  // Counter values used by the logic
  localparam logic [SC_W-1:0]      SC_FIRST     = 9'h000;
  localparam logic [SC_W-1:0]      SC_XFER      = 9'h010;
  localparam logic [SC_W-1:0]      SC_LAST_BIT  = 9'h00F;
  localparam logic [SC_W-1:0]      SC_ONE       = 9'h001;
  localparam logic [SC_W-1:0]      SC_LAST_SHORT = 9'h0FF;
  localparam logic [SC_W-1:0]      SC_LAST_LONG = 9'h1FF;
  localparam logic [3:0]           BIT_LAST     = 4'hF;
  localparam logic [3:0]           BIT_ONE      = 4'h1;
  localparam logic [3:0]           BIT_FIRST    = 4'h0;
  localparam logic [CASCADE_W-1:0] CASCADE_MAX  = 4'h4;
  localparam logic [DIV_W-1:0]     DIV_ONE      = 8'h01;
  localparam logic [DIV_W-1:0]     DIV_ZERO     = 8'h00;

  typedef logic [XFER_BITS-1:0] csc_word_t;

  typedef enum logic [1:0] {CSC_OFF, CSC_MASTER, CSC_SLAVE} csc_mode_e;

  // Everything the block drives onto the serial pins
  typedef struct packed {
    logic sclk;
    logic sclk_oe;
    logic fs;
    logic fs_oe;
    logic dout;
    logic dout_oe;
  } csc_pins_s;

  localparam csc_pins_s PINS_IDLE = '{sclk: 1'b0, sclk_oe: 1'b0, fs: 1'b1, fs_oe: 1'b0,
                                      dout: 1'b0, dout_oe: 1'b0};
  localparam csc_word_t WORD_ZERO = 16'h0000;

endpackage

// [design/csc_serial_port.sv]
// Serial port clocking, role select, power-down and reset for the voice codec
// Operation
// - Select pin high master, low slave
// - Sleep low disables port and clocks
// - Sleep restarts counters, keeps programmed words
// - Reset loads every register default
// - Master frame 256 or 512 shift clocks
// - Bits move only inside frame sync
// - Internal clocks derive from master clock
// - Sample falling, drive rising, float idle
// - Master makes frame sync, slave receives
// - Transfer is 16 clocks from sync fall
`timescale 1ns/1ps
module csc_serial_port
#(
  parameter int SCLK_HALF = csc_pkg::SCLK_HALF_DEFAULT
)(
  // System clock and reset
  input  wire logic                     clock,
  input  wire logic                     rstn,
  // Link shift clock from the pin, slave role
  input  wire logic                     link_sclk,
  // Straps and control pins
  input  wire logic                     ms_select,
  input  wire logic                     sleep_request_n,
  input  wire logic [csc_pkg::CASCADE_W-1:0] cascade_count,
  // Serial pin inputs
  input  wire logic                     frame_sync_in,
  input  wire logic                     data_in,
  // Serial pin outputs
  output csc_pkg::csc_pins_s            pins,
  // User side transmit word
  input  wire csc_pkg::csc_word_t       tx_word,
  input  wire logic                     tx_load,
  // User side receive word
  output csc_pkg::csc_word_t            rx_word,
  output logic                          rx_valid,
  output logic                          frame_tick
);
  import csc_pkg::*;
  localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(SCLK_HALF - 1);
  // Pin synchronisers, system domain
  logic [1:0]           ms_sync;
  logic [1:0]           awake_sync;
  logic [1:0]           din_sync;
  logic [CASCADE_W-1:0] casc_meta;
  logic [CASCADE_W-1:0] casc_q;

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      ms_sync    <= 2'h0;
      awake_sync <= 2'h0;
      din_sync   <= 2'h0;
      casc_meta  <= 4'h0;
      casc_q     <= 4'h0;
    end
    else
    begin
      ms_sync    <= {ms_sync[0], ms_select};
      awake_sync <= {awake_sync[0], sleep_request_n};
      din_sync   <= {din_sync[0], data_in};
      casc_meta  <= cascade_count;
      casc_q     <= casc_meta;
    end

  // Role register
  csc_mode_e mode;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      mode <= CSC_OFF;
    else if (!awake_sync[1])
      mode <= CSC_OFF;
    else if (ms_sync[1])
      mode <= CSC_MASTER;
    else
      mode <= CSC_SLAVE;

  // Programmed transmit word survives sleep
  csc_word_t tx_hold;
  logic      tx_tgl;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      tx_hold <= WORD_ZERO;
      tx_tgl  <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_hold <= tx_word;
      tx_tgl  <= ~tx_tgl;
    end

  // Master shift clock divider
  logic            m_run;
  logic [DIV_W-1:0] m_div;
  logic            m_sclk;
  logic            half_end;
  logic            m_rise;
  logic            m_fall;
  assign m_run    = (mode == CSC_MASTER);
  assign half_end = m_run && (m_div == HALF_LAST);
  assign m_rise   = half_end && !m_sclk;
  assign m_fall   = half_end && m_sclk;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      m_div  <= DIV_ZERO;
      m_sclk <= 1'b0;
    end
    else if (!m_run || half_end)
    begin
      m_div  <= DIV_ZERO;
      m_sclk <= m_run && !m_sclk;
    end
    else
      m_div <= m_div + DIV_ONE;

  // Frame position in shift clocks
  logic [SC_W-1:0] m_sc;
  logic [SC_W-1:0] frame_last;
  logic [SC_W-1:0] next_sc;
  // long frame above four cascaded parts
  assign frame_last = (casc_q > CASCADE_MAX) ? SC_LAST_LONG : SC_LAST_SHORT;
  assign next_sc    = (m_sc >= frame_last) ? SC_FIRST : m_sc + SC_ONE;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      m_sc <= SC_LAST_LONG;
    // restart so next rise opens a frame
    else if (!m_run)
      m_sc <= frame_last;
    else if (m_rise)
      m_sc <= next_sc;

  // Master frame sync and data out, changed on rising edge
  logic      m_fs;
  logic      m_dout;
  logic      m_oe;
  csc_word_t m_tx;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      m_fs   <= 1'b1;
      m_dout <= 1'b0;
      m_oe   <= 1'b0;
      m_tx   <= WORD_ZERO;
    end
    else if (!m_run)
    begin
      m_fs <= 1'b1;
      m_oe <= 1'b0;
    end
    else if (m_rise)
    begin
      m_fs <= (next_sc >= SC_XFER);
      m_oe <= (next_sc < SC_XFER);
      if (next_sc == SC_FIRST)
      begin
        m_dout <= tx_hold[XFER_BITS-1];
        m_tx   <= {tx_hold[XFER_BITS-2:0], 1'b0};
      end
      else if (next_sc < SC_XFER)
      begin
        m_dout <= m_tx[XFER_BITS-1];
        m_tx   <= {m_tx[XFER_BITS-2:0], 1'b0};
      end
    end

  // Master receive, sampled on falling edge
  csc_word_t m_rx;
  logic      m_rx_done;
  logic      m_strobe;
  assign m_strobe = m_fall && (m_sc < SC_XFER);
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      m_rx      <= WORD_ZERO;
      m_rx_done <= 1'b0;
    end
    else
    begin
      if (m_strobe)
        m_rx <= {m_rx[XFER_BITS-2:0], din_sync[1]};
      m_rx_done <= m_strobe && (m_sc == SC_LAST_BIT);
    end

  // Link domain: slave role on the external shift clock
  logic [1:0] l_ms_sync;
  logic [1:0] l_awake_sync;
  logic [2:0] l_tx_sync;
  csc_word_t  l_tx;
  logic       l_active;
  assign l_active = l_awake_sync[1] && !l_ms_sync[1];
  always_ff @(posedge link_sclk or negedge rstn)
    if (!rstn)
    begin
      l_ms_sync    <= 2'h0;
      l_awake_sync <= 2'h0;
      l_tx_sync    <= 3'h0;
      l_tx         <= WORD_ZERO;
    end
    else
    begin
      l_ms_sync    <= {l_ms_sync[0], ms_select};
      l_awake_sync <= {l_awake_sync[0], sleep_request_n};
      l_tx_sync    <= {l_tx_sync[1:0], tx_tgl};
      // Word was stable before its toggle crossed
      if (l_tx_sync[2] != l_tx_sync[1])
        l_tx <= tx_hold;
    end

  // Slave data out on rising edge
  logic      s_dout;
  logic      s_oe;
  csc_word_t s_tx;
  always_ff @(posedge link_sclk or negedge rstn)
    if (!rstn)
    begin
      s_dout <= 1'b0;
      s_oe   <= 1'b0;
      s_tx   <= WORD_ZERO;
    end
    // frame sync taken as synchronous to this clock
    else if (!l_active || frame_sync_in)
    begin
      s_oe <= 1'b0;
      s_tx <= l_tx;
    end
    else
    begin
      s_oe   <= 1'b1;
      s_dout <= s_tx[XFER_BITS-1];
      s_tx   <= {s_tx[XFER_BITS-2:0], 1'b0};
    end

  // Slave receive on falling edge
  logic [3:0] s_bit;
  csc_word_t  s_rx;
  csc_word_t  s_rx_word;
  logic       s_rx_tgl;
  always_ff @(negedge link_sclk or negedge rstn)
    if (!rstn)
    begin
      s_bit     <= BIT_FIRST;
      s_rx      <= WORD_ZERO;
      s_rx_word <= WORD_ZERO;
      s_rx_tgl  <= 1'b0;
    end
    else if (!l_active || frame_sync_in)
      s_bit <= BIT_FIRST;
    else
    begin
      s_bit <= s_bit + BIT_ONE;
      s_rx  <= {s_rx[XFER_BITS-2:0], data_in};
      if (s_bit == BIT_LAST)
      begin
        s_rx_word <= {s_rx[XFER_BITS-2:0], data_in};
        s_rx_tgl  <= ~s_rx_tgl;
      end
    end

  // Received word back into the system domain
  logic [2:0] rx_sync;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      rx_sync    <= 3'h0;
      rx_word    <= WORD_ZERO;
      rx_valid   <= 1'b0;
      frame_tick <= 1'b0;
    end
    else
    begin
      rx_sync    <= {rx_sync[1:0], s_rx_tgl};
      frame_tick <= m_rise && (next_sc == SC_FIRST);
      rx_valid   <= m_rx_done || (rx_sync[2] != rx_sync[1]);
      if (m_rx_done)
        rx_word <= m_rx;
      else if (rx_sync[2] != rx_sync[1])
        rx_word <= s_rx_word;
    end

  // Pin outputs: role picks which domain's flops reach the pins
  always_comb
  begin
    pins = PINS_IDLE;
    if (mode == CSC_MASTER)
      pins = '{sclk: m_sclk, sclk_oe: 1'b1, fs: m_fs, fs_oe: 1'b1, dout: m_dout, dout_oe: m_oe};
    else if (mode == CSC_SLAVE)
      pins = '{sclk: 1'b0, sclk_oe: 1'b0, fs: 1'b1, fs_oe: 1'b0, dout: s_dout, dout_oe: s_oe};
  end

  AST_MASTER_DRIVES: assert property (@(posedge clock) disable iff (!rstn)
    (ms_sync[1] && awake_sync[1]) |=> (pins.sclk_oe && pins.fs_oe))
    else $error("master role without shift clock drive");
  // Pins drop one clock later, the master enable flop one clock after that
  AST_SLEEP_FLOAT: assert property (@(posedge clock) disable iff (!rstn)
    !awake_sync[1] |=> (!pins.sclk_oe && !pins.fs_oe && !pins.dout_oe) ##1 !m_oe)
    else $error("pins driven while asleep");
  AST_WAKE_RESTART: assert property (@(posedge clock) disable iff (!rstn)
    (m_run && !$past(m_run)) |-> (m_sc == frame_last && m_fs))
    else $error("wake did not restart frame");
  AST_FRAME_WRAP: assert property (@(posedge clock) disable iff (!rstn)
    (m_rise && m_sc == frame_last) |=> (m_sc == SC_FIRST && !m_fs))
    else $error("frame length wrong");
  AST_SYNC_LOW16: assert property (@(posedge clock) disable iff (!rstn)
    (m_run && $past(m_run) && !$past(m_rise)) |-> (m_fs == (m_sc >= SC_XFER)))
    else $error("frame sync not low for sixteen clocks");
  AST_STROBE_IN_FRAME: assert property (@(posedge clock) disable iff (!rstn)
    m_strobe |-> (!m_fs && m_oe))
    else $error("sample outside frame sync");
  AST_DOUT_IDLE: assert property (@(posedge clock) disable iff (!rstn)
    (m_run && m_fs) |-> !m_oe)
    else $error("data out driven outside frame");
  AST_SCLK_DIV: assert property (@(posedge clock) disable iff (!rstn)
    (m_run && $past(m_run) && !half_end) |=> $stable(m_sclk))
    else $error("shift clock changed off the divider");
  AST_RX_AFTER_16: assert property (@(posedge clock) disable iff (!rstn)
    (m_strobe && m_sc == SC_LAST_BIT) |=> m_rx_done ##1 rx_valid)
    else $error("word not delivered after sixteenth bit");
endmodule // csc_serial_port

// [verif/csc_host_model.sv]
// Host processor model on the codec serial pins
`timescale 1ns/1ps
module csc_host_model (
  // Role and words
  input  wire logic               slave_role,
  input  wire logic               start,
  input  wire csc_pkg::csc_word_t send_word,
  output csc_pkg::csc_word_t      got_word,
  // Serial pins
  input  wire csc_pkg::csc_pins_s pins,
  output logic                    link_sclk,
  output logic                    frame_sync_in,
  output logic                    data_in
);
  import csc_pkg::*;
  logic sclk_w;
  logic fs_w;
  int   idx;
  assign sclk_w = slave_role ? link_sclk : pins.sclk;
  assign fs_w   = slave_role ? frame_sync_in : pins.fs;
  initial
  begin
    link_sclk = 1'b0;
    frame_sync_in = 1'b1;
    data_in = 1'b0;
    idx = 15;
  end
  // supplied shift clock
  // Phase offset keeps link edges clear of system edges
  initial
  begin
    #7;
    forever #15 link_sclk = slave_role ? ~link_sclk : 1'b0;
  end
  // Cut or ended frame restarts the word
  always @(posedge fs_w)
    idx = 15;
  always @(posedge start)
  begin
    @(negedge link_sclk);
    frame_sync_in <= 1'b0;
    repeat (16) @(negedge link_sclk);
    frame_sync_in <= 1'b1;
  end
  always @(posedge sclk_w)
  begin
    #1;
    if (!fs_w)
    begin
      data_in = send_word[idx];
      idx = idx - 1;
    end
    else
    begin
      // Idle line toggles so a stale bit never passes
      data_in = ~data_in;
      idx = 15;
    end
  end
  always @(negedge sclk_w)
    if (!fs_w)
      // Released line reads as the inverse so a float never passes
      got_word <= {got_word[14:0], pins.dout_oe ? pins.dout : ~pins.dout};
endmodule // csc_host_model

// [verif/test_codec_serial_clock_power_ctl.sv]
// Self-checking bench for the codec serial clock and power control block
`timescale 1ns/1ps
module test_codec_serial_clock_power_ctl;
  import csc_pkg::*;
  localparam int HALF = 4;
  localparam int PER = 2 * HALF;
  logic clock;
  logic rstn;
  logic link_sclk;
  logic ms_select;
  logic sleep_request_n;
  logic [CASCADE_W-1:0] cascade_count;
  logic frame_sync_in;
  logic data_in;
  logic tx_load;
  logic rx_valid;
  logic frame_tick;
  logic start;
  csc_pins_s pins;
  csc_word_t tx_word;
  csc_word_t rx_word;
  csc_word_t host_word;
  csc_word_t got_word;
  int mismatches;
  int checks;
  int cycles = 0;
  int bad;
  int n;
  int low;
  int tk;

  csc_serial_port #(.SCLK_HALF(HALF)) u_csc_serial_port (
    .clock(clock), .rstn(rstn), .link_sclk(link_sclk), .ms_select(ms_select),
    .sleep_request_n(sleep_request_n), .cascade_count(cascade_count), .frame_sync_in(frame_sync_in),
    .data_in(data_in), .pins(pins), .tx_word(tx_word), .tx_load(tx_load), .rx_word(rx_word),
    .rx_valid(rx_valid), .frame_tick(frame_tick));

  csc_host_model u_csc_host_model (
    .slave_role(~ms_select), .start(start), .send_word(host_word), .got_word(got_word),
    .pins(pins), .link_sclk(link_sclk), .frame_sync_in(frame_sync_in), .data_in(data_in));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Clocks up to the next frame sync fall
  task automatic fs_fall;
    logic was;
    was = 1'b0;
    n = 0;
    low = 0;
    tk = 0;
    while (!(was && pins.fs === 1'b0) && n < 5000)
    begin
      was = pins.fs;
      @(negedge clock);
      n++;
      if (pins.fs === 1'b0) low++;
      if (frame_tick === 1'b1) tk++;
      if (pins.dout_oe !== ~pins.fs) bad++;
    end
  endtask

  task automatic t_master;
    int cc [3] = '{4, 5, 1};
    @(posedge clock);
    ms_select <= 1'b1;
    tx_word <= 16'hA5C3;
    host_word <= 16'h3C96;
    tx_load <= 1'b1;
    @(posedge clock);
    tx_load <= 1'b0;
    foreach (cc[i])
    begin
      @(posedge clock);
      cascade_count <= 4'(cc[i]);
      fs_fall();
      fs_fall();
      bad = 0;
      fs_fall();
      check("frame clocks", 16'((cc[i] > 4 ? 512 : 256) * PER), 16'(n));
      check("sync low clocks", 16'(16 * PER), 16'(low));
      check("frame ticks", 16'h0001, 16'(tk));
      check("oe follows sync", 16'h0000, 16'(bad));
    end
    check("master tx", 16'hA5C3, got_word);
    check("master rx", 16'h3C96, rx_word);
    check("master drives", 16'h0003, {14'h0, pins.sclk_oe, pins.fs_oe});
  endtask

  task automatic t_sleep;
    @(posedge clock);
    sleep_request_n <= 1'b0;
    host_word <= 16'h1E2D;
    repeat (10) @(negedge clock);
    check("sleep oe", 16'h0000, {13'h0, pins.sclk_oe, pins.fs_oe, pins.dout_oe});
    check("sleep keeps rx", 16'h3C96, rx_word);
    @(posedge clock);
    sleep_request_n <= 1'b1;
    fs_fall();
    check("wake restart", 16'h0001, {15'h0, n <= 12});
    fs_fall();
    check("wake frame", 16'(256 * PER), 16'(n));
    check("wake keeps tx", 16'hA5C3, got_word);
    check("wake rx", 16'h1E2D, rx_word);
  endtask

  task automatic t_slave;
    @(posedge clock);
    ms_select <= 1'b0;
    tx_word <= 16'h5A0F;
    host_word <= 16'hC3A5;
    tx_load <= 1'b1;
    @(posedge clock);
    tx_load <= 1'b0;
    repeat (10) @(posedge clock);
    check("slave releases", 16'h0000, {14'h0, pins.sclk_oe, pins.fs_oe});
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    n = 0;
    while (rx_valid !== 1'b1 && n < 100)
    begin
      @(negedge clock);
      n++;
    end
    check("slave rx valid", 16'h0001, {15'h0, rx_valid});
    check("slave rx", 16'hC3A5, rx_word);
    check("slave tx", 16'h5A0F, got_word);
  endtask

  task automatic t_reset;
    @(posedge clock);
    rstn <= 1'b0;
    repeat (3) @(negedge clock);
    check("reset rx", 16'h0000, rx_word);
    check("reset oe", 16'h0000, {13'h0, pins.sclk_oe, pins.fs_oe, pins.dout_oe});
    @(posedge clock);
    rstn <= 1'b1;
  endtask

  // Cut a hang short
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      mismatches++;
      end_sim();
    end
  end

  initial
  begin
    rstn = 1'b0;
    ms_select = 1'b0;
    sleep_request_n = 1'b1;
    cascade_count = 4'h0;
    tx_word = 16'h0000;
    tx_load = 1'b0;
    start = 1'b0;
    host_word = 16'h0000;
    mismatches = 0;
    checks = 0;
    bad = 0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    t_master();
    t_sleep();
    t_slave();
    t_reset();
    end_sim();
  end
endmodule // test_codec_serial_clock_power_ctl
